/* File: pkg/stage_regs_consts.vh */
/*
  constants of the stage source-select and drive-state register bank.
  assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef STAGE_REGS_CONSTS_VH
`define STAGE_REGS_CONSTS_VH

// ==========================================================
// reset values
`define SOURCE_SELECT_LO_RST 8'h80
`define SOURCE_SELECT_HI_RST 8'h00
`define DRIVE_STATE_LO_RST 8'hff
`define DRIVE_STATE_MID_RST 8'hff
`define DRIVE_STATE_HI_RST 2'h3
`define DRIVE_STATE_HI_FILL 6'h3f

// ==========================================================
// instruction byte layout
`define INSTR_ADDR_MSB 7
`define INSTR_ADDR_LSB 6
`define INSTR_CODE_MSB 5
`define INSTR_CODE_LSB 1
`define INSTR_ADDR_DEVICE 2'h0

// ==========================================================
// instruction codes
`define CODE_WR_SOURCE_LO 5'h12
`define CODE_WR_SOURCE_HI 5'h13
`define CODE_WR_DRIVE_LO 5'h14
`define CODE_WR_DRIVE_MID 5'h15
`define CODE_WR_DRIVE_HI 5'h16
`define CODE_RD_SOURCE_LO 5'h02
`define CODE_RD_SOURCE_HI 5'h03
`define CODE_RD_DRIVE_LO 5'h04
`define CODE_RD_DRIVE_MID 5'h05
`define CODE_RD_DRIVE_HI 5'h06

// ==========================================================
// frame counts
`define FRAME_BITS 5'h10
`define INSTR_BITS 5'h08
`define FRAME_OVER 5'h11

// ==========================================================
// stage numbering
`define INVERTED_STAGE 7

`endif

/* File: logic/pin_filter.v */
/*
  three-flop synchroniser with agreement filter for a group of pins.
  assumes the pins are asynchronous to i_ref_clk.
*/
module pin_filter #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [WIDTH-1:0] i_pin,
    output reg [WIDTH-1:0] o_level
);
    reg [WIDTH-1:0] sync_1;
    reg [WIDTH-1:0] sync_2;
    reg [WIDTH-1:0] sync_3;
    genvar g;

    // ==========================================================
    // per-bit filter: change taken only when stages two and three agree
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : bit_filter
            always @(posedge i_ref_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    sync_1[g] <= RESET_VALUE[g];
                    sync_2[g] <= RESET_VALUE[g];
                    sync_3[g] <= RESET_VALUE[g];
                    o_level[g] <= RESET_VALUE[g];
                end else begin
                    sync_1[g] <= i_pin[g];
                    sync_2[g] <= sync_1[g];
                    sync_3[g] <= sync_2[g];
                    if (sync_2[g] == sync_3[g]) begin
                        o_level[g] <= sync_3[g];
                    end
                end
            end
        end
    endgenerate
endmodule // pin_filter

/* File: logic/output_source_and_drive_regs.v */
/*
  serial-interface register bank choosing and commanding the 18 low-side stages.
  assumes a serial master on chip select, shift clock and data in, mode 0
  (sample on rising, shift on falling), 16 bits per frame; pins are asynchronous.
  stage vectors: bit k is stage k+1; a one means on at o_stage_output, off at i_usec_stage_state and in the drive-state registers.
*/
// Functional notes
// - source-select low register, stages 1-8, bit n is stage n+1, resets 80h.
// - source-select high register, stages 9-16, bit n is stage n+9, resets 00h.
// - drive-state low register, stages 1-8, resets ffh.
// - drive-state mid register, stages 9-16, resets ffh.
// - drive-state high register, bit 0 stage 17, bit 1 stage 18, resets ffh.
// - drive-state high bits 7 to 2 always read one, writes ignored.
// - all five registers writable and readable, read returns last written except drive-state high bits 7 to 2.
// - serial control with enable: stage on when drive bit 0, off when 1.
// - select bit one: bus-select picks parallel pin or high-speed register; stage 8 has no high-speed bit and goes off instead.
// - stages 17 and 18 follow only their drive bits.
`include "stage_regs_consts.vh"

module output_source_and_drive_regs (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_spi_cs_n,
    input wire i_spi_sclk,
    input wire i_spi_si,
    output reg o_spi_so,
    output wire o_spi_so_oe_n,
    input wire i_outputs_enabled_flag,
    input wire i_bus_select,
    input wire [15:0] i_parallel_stage_input,
    input wire [15:0] i_usec_stage_state,
    output reg [17:0] o_stage_output
);
    wire [2:0] spi_level;
    wire [15:0] parallel_level;
    wire cs_n;
    wire sclk;
    wire si;
    reg cs_n_prev;
    reg sclk_prev;
    reg [15:0] shift_in;
    reg [4:0] bit_cnt;
    reg [7:0] instr;
    reg [7:0] tx;
    reg [7:0] stage_source_select_lo;
    reg [7:0] stage_source_select_hi;
    reg [7:0] serial_drive_state_lo;
    reg [7:0] serial_drive_state_mid;
    reg [1:0] serial_drive_state_hi;
    reg [7:0] read_data;
    reg [17:0] next_stage_output;
    wire [15:0] source_bits;
    wire [15:0] drive_bits;
    wire [7:0] new_instr;
    wire instr_ok;
    wire [4:0] code;
    wire frame_start;
    wire frame_end;
    wire sclk_rise;
    wire sclk_fall;
    wire rd_ok;
    wire [4:0] rd_code;
    wire write_strobe;
    wire [15:0] stage_on;
    genvar g;

    // ==========================================================
    // pin synchronisers
    // the filters reset to the idle pin levels, so no false edge follows reset
    pin_filter #(.WIDTH(3), .RESET_VALUE(3'h1)) spi_filter (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin({i_spi_si, i_spi_sclk, i_spi_cs_n}),
        .o_level(spi_level)
    );
    pin_filter #(.WIDTH(16), .RESET_VALUE(16'hffff)) par_filter (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_parallel_stage_input),
        .o_level(parallel_level)
    );
    assign cs_n = spi_level[0];
    assign sclk = spi_level[1];
    assign si = spi_level[2];
    // the data pin is released whenever the filtered select is high
    assign o_spi_so_oe_n = cs_n;

    // ==========================================================
    // edge decode on the filtered pins
    // edges use filtered levels, so a one-clock pin glitch never counts as a shift
    assign frame_start = cs_n_prev && !cs_n;
    assign frame_end = !cs_n_prev && cs_n;
    assign sclk_rise = !cs_n && sclk && !sclk_prev;
    assign sclk_fall = !cs_n && !sclk && sclk_prev;

    // ==========================================================
    // instruction check: device address 00 and even parity over the byte
    assign new_instr = {shift_in[6:0], si};
    assign instr_ok = (instr[`INSTR_ADDR_MSB:`INSTR_ADDR_LSB] == `INSTR_ADDR_DEVICE)
                      && !(^instr);
    assign code = instr[`INSTR_CODE_MSB:`INSTR_CODE_LSB];
    // only a whole frame with a good instruction byte may write
    assign write_strobe = frame_end && (bit_cnt == `FRAME_BITS) && instr_ok;
    // reads decode the byte as its last bit arrives, so the answer fills the data byte
    assign rd_ok = (new_instr[`INSTR_ADDR_MSB:`INSTR_ADDR_LSB] == `INSTR_ADDR_DEVICE)
                   && !(^new_instr);
    assign rd_code = new_instr[`INSTR_CODE_MSB:`INSTR_CODE_LSB];

    // ==========================================================
    // read mux
    always @* begin
        read_data = 8'h00;
        if (!rd_ok) begin
            read_data = 8'h00;
        end else if (rd_code == `CODE_RD_SOURCE_LO) begin
            read_data = stage_source_select_lo;
        end else if (rd_code == `CODE_RD_SOURCE_HI) begin
            read_data = stage_source_select_hi;
        end else if (rd_code == `CODE_RD_DRIVE_LO) begin
            read_data = serial_drive_state_lo;
        end else if (rd_code == `CODE_RD_DRIVE_MID) begin
            read_data = serial_drive_state_mid;
        end else if (rd_code == `CODE_RD_DRIVE_HI) begin
            read_data = {`DRIVE_STATE_HI_FILL, serial_drive_state_hi};
        end
    end

    // ==========================================================
    // frame engine and registers
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cs_n_prev <= 1'b1;
            sclk_prev <= 1'b0;
            shift_in <= 16'h0000;
            bit_cnt <= 5'h00;
            instr <= 8'h00;
            tx <= 8'h00;
            o_spi_so <= 1'b0;
            stage_source_select_lo <= `SOURCE_SELECT_LO_RST;
            stage_source_select_hi <= `SOURCE_SELECT_HI_RST;
            serial_drive_state_lo <= `DRIVE_STATE_LO_RST;
            serial_drive_state_mid <= `DRIVE_STATE_MID_RST;
            serial_drive_state_hi <= `DRIVE_STATE_HI_RST;
        end else begin
            cs_n_prev <= cs_n;
            sclk_prev <= sclk;
            // a fresh select drops whatever a cut frame left behind
            if (frame_start) begin
                bit_cnt <= 5'h00;
                shift_in <= 16'h0000;
                tx <= 8'h00;
                o_spi_so <= 1'b0;
            end else if (sclk_rise) begin
                shift_in <= {shift_in[14:0], si};
                if (bit_cnt != `FRAME_OVER) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
                if (bit_cnt == `INSTR_BITS - 5'h01) begin
                    // answer goes out in the same frame's data byte
                    instr <= new_instr;
                    tx <= read_data;
                    o_spi_so <= read_data[7];
                end
            end else if (sclk_fall && bit_cnt > `INSTR_BITS) begin
                tx <= {tx[6:0], 1'b0};
                o_spi_so <= tx[6];
            end else if (frame_end) begin
                // a short or long frame writes nothing
                if (write_strobe) begin
                    if (code == `CODE_WR_SOURCE_LO) begin
                        stage_source_select_lo <= shift_in[7:0];
                    end else if (code == `CODE_WR_SOURCE_HI) begin
                        stage_source_select_hi <= shift_in[7:0];
                    end else if (code == `CODE_WR_DRIVE_LO) begin
                        serial_drive_state_lo <= shift_in[7:0];
                    end else if (code == `CODE_WR_DRIVE_MID) begin
                        serial_drive_state_mid <= shift_in[7:0];
                    end else if (code == `CODE_WR_DRIVE_HI) begin
                        serial_drive_state_hi <= shift_in[1:0];
                    end
                end
            end
        end
    end

    // ==========================================================
    // stage drive: one selector per stage that has a parallel pin
    assign source_bits = {stage_source_select_hi, stage_source_select_lo};
    assign drive_bits = {serial_drive_state_mid, serial_drive_state_lo};

    generate
        for (g = 0; g < 16; g = g + 1) begin : stage_select
            if (g == `INVERTED_STAGE) begin : no_fast_bus
                // this stage has no high-speed bus bit, so that source holds it off;
                // its pin is non-inverting, unlike every other stage
                assign stage_on[g] = !source_bits[g] ? !drive_bits[g]
                                     : (i_bus_select && parallel_level[g]);
            end else begin : with_fast_bus
                assign stage_on[g] = !source_bits[g] ? !drive_bits[g]
                                     : i_bus_select ? !parallel_level[g]
                                     : !i_usec_stage_state[g];
            end
        end
    endgenerate

    // the enable gates every stage in one place, so no source can bypass it
    always @* begin
        next_stage_output = 18'h00000;
        if (i_outputs_enabled_flag) begin
            next_stage_output[15:0] = stage_on;
            next_stage_output[16] = !serial_drive_state_hi[0];
            next_stage_output[17] = !serial_drive_state_hi[1];
        end
    end

    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_stage_output <= 18'h00000;
        end else begin
            o_stage_output <= next_stage_output;
        end
    end
endmodule // output_source_and_drive_regs

/* File: dv/output_source_and_drive_regs_properties.sv */
/* port checker for the stage register bank.
   assumes one clock and i_sys_rst async, active high; bound after the module. */
module stage_regs_checker (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_spi_cs_n,
    input wire i_spi_sclk,
    input wire i_spi_si,
    input wire o_spi_so,
    input wire o_spi_so_oe_n,
    input wire i_outputs_enabled_flag,
    input wire i_bus_select,
    input wire [15:0] i_parallel_stage_input,
    input wire [15:0] i_usec_stage_state,
    input wire [17:0] o_stage_output
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================
    // stage outputs
    off_disabled_a:
        assert property (!i_outputs_enabled_flag |=> o_stage_output == 18'h00000)
        else $error("stage on while disabled");
    // serial-only stages move on an enable edge or a frame end, never on bus select
    high_stages_quiet_a:
        assert property ($changed(o_stage_output[17:16]) && $past(i_outputs_enabled_flag)
            && $past(i_outputs_enabled_flag, 2) |-> !$past(o_spi_so_oe_n, 4))
        else $error("stage 17 or 18 moved outside a frame end");
    outputs_hold_a:
        assert property ((i_spi_cs_n && $stable({i_outputs_enabled_flag, i_bus_select,
            i_parallel_stage_input, i_usec_stage_state})) [*8] |-> $stable(o_stage_output))
        else $error("stage outputs moved with quiet inputs");
    // ==========================================
    // serial port
    so_release_a:
        assert property (i_spi_cs_n [*5] |-> o_spi_so_oe_n)
        else $error("data out driven while deselected");
    so_drive_a:
        assert property (!i_spi_cs_n [*5] |-> !o_spi_so_oe_n)
        else $error("data out not driven while selected");
    select_rise_a:
        assert property ($rose(o_spi_so_oe_n) |-> $past(i_spi_cs_n, 3))
        else $error("release without deselect");
    select_fall_a:
        assert property ($fell(o_spi_so_oe_n) |-> !$past(i_spi_cs_n, 3))
        else $error("drive without select");
    so_quiet_a:
        assert property ((i_spi_cs_n && !i_spi_sclk) [*8] |-> $stable(o_spi_so))
        else $error("data out moved while idle");
endmodule // stage_regs_checker

bind output_source_and_drive_regs stage_regs_checker chk (.i_ref_clk, .i_sys_rst,
    .i_spi_cs_n, .i_spi_sclk, .i_spi_si, .o_spi_so, .o_spi_so_oe_n, .i_outputs_enabled_flag,
    .i_bus_select, .i_parallel_stage_input, .i_usec_stage_state, .o_stage_output);

/* File: dv/spi_host_model.sv */
/* host serial master model: 16-bit frames, msb first, sample on rising.
   assumes i_ref_clk is the device clock; the bench calls xfer. */
module spi_host_model (
    input wire logic i_ref_clk,
    input wire logic i_so,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // frame engine
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end
    // 8-clock phases keep every pin edge clear of the device's input filter delay
    task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] w;
        w = {ins, dat};
        rd = 8'h00;
        @(posedge i_ref_clk) o_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_si <= w[i];
            repeat (8) @(posedge i_ref_clk);
            if (i < 8) rd[i] = i_so;
            o_sclk <= 1'b1;
            repeat (8) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
        end
        repeat (8) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        // a released line never keeps the last bit
        o_si <= ~w[0];
        repeat (12) @(posedge i_ref_clk);
    endtask
endmodule // spi_host_model

/* File: dv/output_source_and_drive_regs_bench.sv */
/* self-checking bench for the stage register bank.
   assumes the host model drives the serial pins; 40 MHz clock. */
`include "stage_regs_consts.vh"
module output_source_and_drive_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic bsel = 1'b0;
    logic [15:0] par = 16'hffff;
    logic [15:0] usec = 16'hffff;
    logic cs_n, sclk, si;
    wire so, so_oe_n;
    wire [17:0] stage;
    int n_errors = 0;
    int total_checks = 0;
    logic [7:0] rd;
    logic [15:0] sel = 16'h0080;
    logic [17:0] drv = 18'h3ffff;
    always #12.5 clk = ~clk;
    spi_host_model host (.i_ref_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));
    output_source_and_drive_regs dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_spi_cs_n(cs_n),
        .i_spi_sclk(sclk), .i_spi_si(si), .o_spi_so(so), .o_spi_so_oe_n(so_oe_n),
        .i_outputs_enabled_flag(en), .i_bus_select(bsel), .i_parallel_stage_input(par),
        .i_usec_stage_state(usec), .o_stage_output(stage));
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] ins(input logic [4:0] c);
        return {2'b00, c, ^c};
    endfunction
    task automatic wr_reg(input logic [4:0] c, input logic [7:0] d);
        host.xfer(ins(c), d, rd);
    endtask
    task automatic rd_reg(input logic [4:0] c, input logic [7:0] exp);
        host.xfer(ins(c), 8'h00, rd);
        check("read", {10'h000, exp}, {10'h000, rd});
    endtask
    function automatic logic [17:0] stage_exp();
        logic [17:0] o;
        for (int k = 0; k < 16; k++)
            if (!sel[k]) o[k] = !drv[k];
            else if (bsel) o[k] = (k == `INVERTED_STAGE) ? par[k] : !par[k];
            else o[k] = (k == `INVERTED_STAGE) ? 1'b0 : !usec[k];
        o[17:16] = ~drv[17:16];
        return en ? o : 18'h00000;
    endfunction
    // ==========================================
    // scenarios
    task automatic t_reset_values();
        rd_reg(`CODE_RD_SOURCE_LO, 8'h80);
        rd_reg(`CODE_RD_SOURCE_HI, 8'h00);
        rd_reg(`CODE_RD_DRIVE_LO, 8'hff);
        rd_reg(`CODE_RD_DRIVE_MID, 8'hff);
        rd_reg(`CODE_RD_DRIVE_HI, 8'hff);
    endtask
    task automatic t_write_read();
        wr_reg(`CODE_WR_SOURCE_LO, 8'hda);
        wr_reg(`CODE_WR_SOURCE_HI, 8'ha5);
        wr_reg(`CODE_WR_DRIVE_LO, 8'h3c);
        wr_reg(`CODE_WR_DRIVE_MID, 8'hc3);
        wr_reg(`CODE_WR_DRIVE_HI, 8'h02);
        sel = 16'ha5da;
        drv = {2'b10, 8'hc3, 8'h3c};
        rd_reg(`CODE_RD_SOURCE_LO, 8'hda);
        rd_reg(`CODE_RD_SOURCE_HI, 8'ha5);
        rd_reg(`CODE_RD_DRIVE_LO, 8'h3c);
        rd_reg(`CODE_RD_DRIVE_MID, 8'hc3);
        rd_reg(`CODE_RD_DRIVE_HI, 8'hfe);
    endtask
    task automatic t_refused();
        host.xfer({2'b00, `CODE_WR_SOURCE_LO, ~^`CODE_WR_SOURCE_LO}, 8'h00, rd);
        host.xfer({2'b01, `CODE_WR_SOURCE_LO, ^`CODE_WR_SOURCE_LO}, 8'h00, rd);
        rd_reg(`CODE_RD_SOURCE_LO, 8'hda);
        host.xfer({2'b00, `CODE_RD_SOURCE_LO, ~^`CODE_RD_SOURCE_LO}, 8'h00, rd);
        check("refused read", 18'h00000, {10'h000, rd});
    endtask
    task automatic t_stages();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            en <= (m != 0);
            bsel <= m[0];
            par <= m[1] ? 16'h0f0f : 16'hf0f0;
            usec <= 16'h3355;
            repeat (10) @(posedge clk);
            check("stages", stage_exp(), stage);
        end
        wr_reg(`CODE_WR_DRIVE_LO, 8'h00);
        drv[7:0] = 8'h00;
        check("after write", stage_exp(), stage);
        wr_reg(`CODE_WR_DRIVE_HI, 8'h01);
        drv[17:16] = 2'b01;
        check("after high write", stage_exp(), stage);
        rd_reg(`CODE_RD_DRIVE_HI, 8'hfd);
    endtask
    // ==========================================
    // run control
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset_values();
        t_write_read();
        t_refused();
        t_stages();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // output_source_and_drive_regs_bench
